// ### verilog/cwep_pkg.sv
// Purpose: Constants and types for the CCD window and event processor
// Assumes: 200 MHz core clock, APB register access
// Notes: Register offsets are byte addresses on a 32-bit APB

package cwep_pkg;
  // ==========================================
  // Timing
  localparam int CLK_NS = 5;
  localparam int HT_NS = 100;
  localparam int VT_NS = 600;
  localparam int HT_CYC = HT_NS / CLK_NS;
  localparam int VT_TICKS = VT_NS / HT_NS;
  localparam int SW_IN_TICKS = 2;
  localparam int SW_OUT_TICKS = 1;
  localparam int ROW_PIX = 407;
  localparam int FLUSH_TICKS = SW_IN_TICKS + ROW_PIX + SW_OUT_TICKS;
  localparam int FT_SHIFTS = 290;
  localparam int POST_ROWS = 2;
  localparam int NUM_PAIRS = 145;
  localparam logic [4:0] HT_LAST = 5'(HT_CYC - 1);
  localparam logic [10:0] VT_LAST = 11'(VT_TICKS - 1);
  localparam logic [10:0] FT_LAST = 11'(FT_SHIFTS * VT_TICKS - 1);
  localparam logic [10:0] FLUSH_LAST = 11'(FLUSH_TICKS - 1);
  localparam logic [10:0] POST_LAST = 11'(POST_ROWS * VT_TICKS - 1);
  localparam logic [10:0] PIX_FIRST = 11'(SW_IN_TICKS);
  localparam logic [10:0] PIX_LAST = 11'(SW_IN_TICKS + ROW_PIX - 1);
  localparam logic [7:0] PAIR_END = 8'(NUM_PAIRS);
  // ==========================================
  // Registers
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_THRESH = 12'h004;
  localparam logic [11:0] REG_TADDR = 12'h008;
  localparam logic [11:0] REG_TDATA = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam int CTRL_TAG_BIT = 3;
  localparam int CTRL_INTEG_BIT = 4;
  localparam int CTRL_READY_BIT = 5;
  localparam int TADDR_SEL_LSB = 16;
  localparam logic [7:0] THRESH_RST = 8'h0F;
  localparam logic [1:0] TSEL_WIN = 2'h0;
  localparam logic [1:0] TSEL_ROW = 2'h1;
  localparam logic [1:0] TSEL_CENX = 2'h2;
  localparam logic [1:0] TSEL_CENY = 2'h3;
  localparam logic [1:0] CODE_READ_EVT = 2'h3;
  localparam int CODE_SKIP_BIT = 3;
  // ==========================================
  // Engineering record types
  localparam logic [2:0] REC_XMN = 3'h1;
  localparam logic [2:0] REC_YMN = 3'h2;
  localparam logic [2:0] REC_HGT = 3'h3;
  localparam logic [2:0] REC_ENE = 3'h4;
  localparam logic [1:0] TAG_WORDS = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_FT = 7'h02,
    ST_DUMP = 7'h04,
    ST_ROWSEL = 7'h08,
    ST_VT = 7'h10,
    ST_FLUSH = 7'h20,
    ST_POST = 7'h40
  } cwep_state_t;
endpackage

// ### verilog/cwep_top.sv
// Purpose: CCD clock sequencer, window readout and event word formatter
// Assumes: Event detector on the same clock gives at most one event per pixel
// Notes: Tables are loaded through an address and data register pair

`timescale 1ns/100ps

module cwep_top import cwep_pkg::*; (
  input logic i_core_clk,
  input logic i_rst,
  input logic i_psel,
  input logic i_penable,
  input logic i_pwrite,
  input logic [11:0] i_paddr,
  input logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input logic i_evt_valid,
  input logic [7:0] i_evt_height,
  input logic [7:0] i_evt_mx,
  input logic [7:0] i_evt_nx,
  input logic [7:0] i_evt_my,
  input logic [7:0] i_evt_ny,
  output logic o_vshift,
  output logic o_hmode,
  output logic o_hpix,
  output logic o_frame_start,
  output logic [23:0] o_word,
  output logic o_word_valid
);

  // ==========================================
  // Register bus
  logic [2:0] mode_reg;
  logic tag_en_reg;
  logic integ_reg;
  logic ready_reg;
  logic [7:0] thresh_reg;
  logic [1:0] tsel_reg;
  logic [15:0] taddr_reg;
  logic apb_acc;
  logic apb_hit;
  logic tbl_we;
  logic [31:0] rd_mux;
  cwep_state_t state_reg;
  logic [7:0] pair_reg;
  logic send_reg;

  assign apb_acc = i_psel & i_penable & o_pready;
  assign apb_hit = (i_paddr == REG_CTRL) | (i_paddr == REG_THRESH) | (i_paddr == REG_TADDR) |
                   (i_paddr == REG_TDATA) | (i_paddr == REG_STATUS);
  assign tbl_we = apb_acc & i_pwrite & (i_paddr == REG_TDATA);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_paddr)
      REG_CTRL: rd_mux = {26'h0, ready_reg, integ_reg, tag_en_reg, mode_reg};
      REG_THRESH: rd_mux = {24'h0, thresh_reg};
      REG_TADDR: rd_mux = {14'h0, tsel_reg, taddr_reg};
      REG_STATUS: rd_mux = {8'h0, pair_reg, 7'h0, send_reg, 1'b0, state_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      o_prdata <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ? rd_mux : 32'h0000_0000;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~apb_hit;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_reg <= 3'h0;
      tag_en_reg <= 1'b1;
      integ_reg <= 1'b0;
      ready_reg <= 1'b0;
      thresh_reg <= THRESH_RST;
    end else if (apb_acc && i_pwrite && i_paddr == REG_CTRL) begin
      mode_reg <= i_pwdata[2:0];
      tag_en_reg <= i_pwdata[CTRL_TAG_BIT];
      integ_reg <= i_pwdata[CTRL_INTEG_BIT];
      ready_reg <= i_pwdata[CTRL_READY_BIT];
    end else if (apb_acc && i_pwrite && i_paddr == REG_THRESH) begin
      thresh_reg <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tsel_reg <= TSEL_WIN;
      taddr_reg <= 16'h0000;
    end else if (apb_acc && i_pwrite && i_paddr == REG_TADDR) begin
      tsel_reg <= i_pwdata[TADDR_SEL_LSB +: 2];
      taddr_reg <= i_pwdata[15:0];
    end else if (tbl_we) begin
      taddr_reg <= taddr_reg + 16'h0001;
    end
  end

  // ==========================================
  // Tables
  logic [3:0] win_mem [0:65535];
  logic [3:0] row_mem [0:255];
  logic [3:0] cenx_mem [0:65535];
  logic [3:0] ceny_mem [0:65535];
  logic [3:0] win_id_reg;
  logic [3:0] row_code_reg;
  logic [3:0] cx_reg;
  logic [3:0] cy_reg;
  logic [10:0] cnt_reg;
  logic half_reg;
  logic [8:0] x_pix;
  logic [8:0] y_pix;

  assign x_pix = 9'(cnt_reg - PIX_FIRST);
  assign y_pix = {pair_reg, half_reg};

  always_ff @(posedge i_core_clk) begin
    if (tbl_we && tsel_reg == TSEL_WIN) begin
      win_mem[taddr_reg] <= i_pwdata[3:0];
    end
    win_id_reg <= win_mem[{y_pix[8:1], x_pix[8:1]}];
  end

  always_ff @(posedge i_core_clk) begin
    if (tbl_we && tsel_reg == TSEL_ROW) begin
      row_mem[taddr_reg[7:0]] <= i_pwdata[3:0];
    end
    row_code_reg <= row_mem[pair_reg];
  end

  always_ff @(posedge i_core_clk) begin
    if (tbl_we && tsel_reg == TSEL_CENX) begin
      cenx_mem[taddr_reg] <= i_pwdata[3:0];
    end
    if (tbl_we && tsel_reg == TSEL_CENY) begin
      ceny_mem[taddr_reg] <= i_pwdata[3:0];
    end
    cx_reg <= cenx_mem[{i_evt_mx, i_evt_nx}];
    cy_reg <= ceny_mem[{i_evt_my, i_evt_ny}];
  end

  // ==========================================
  // Clock sequencer
  logic [4:0] div_reg;
  logic tick;
  logic [3:0] code_reg;
  logic frame_go;
  logic pix_phase;

  assign tick = (div_reg == HT_LAST);
  assign pix_phase = (state_reg == ST_FLUSH) && (cnt_reg >= PIX_FIRST) && (cnt_reg <= PIX_LAST);
  assign frame_go = ((state_reg == ST_IDLE) && ready_reg && tick) ||
                    ((state_reg == ST_POST) && tick && cnt_reg == POST_LAST);

  always_ff @(posedge i_core_clk) begin
    if (i_rst || div_reg == HT_LAST) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 11'h000;
      pair_reg <= 8'h00;
      half_reg <= 1'b0;
      code_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (ready_reg && tick) begin
            state_reg <= ST_FT;
            cnt_reg <= 11'h000;
          end
        end
        ST_FT: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 11'h001;
            if (cnt_reg == FT_LAST) begin
              state_reg <= ST_DUMP;
              cnt_reg <= 11'h000;
            end
          end
        end
        ST_DUMP: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 11'h001;
            if (cnt_reg == FLUSH_LAST) begin
              state_reg <= ST_ROWSEL;
              cnt_reg <= 11'h000;
              pair_reg <= 8'h00;
              half_reg <= 1'b0;
            end
          end
        end
        ST_ROWSEL: begin
          if (cnt_reg == 11'h000) begin
            cnt_reg <= 11'h001;
          end else if (tick) begin
            cnt_reg <= 11'h000;
            code_reg <= row_code_reg;
            state_reg <= (pair_reg == PAIR_END) ? ST_POST : ST_VT;
          end
        end
        ST_VT: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 11'h001;
            if (cnt_reg == VT_LAST) begin
              cnt_reg <= 11'h000;
              if (code_reg[1]) begin
                state_reg <= ST_FLUSH;
              end else if (!half_reg) begin
                half_reg <= 1'b1;
              end else if (code_reg[CODE_SKIP_BIT]) begin
                state_reg <= ST_POST;
              end else begin
                half_reg <= 1'b0;
                pair_reg <= pair_reg + 8'h01;
                state_reg <= ST_ROWSEL;
              end
            end
          end
        end
        ST_FLUSH: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 11'h001;
            if (cnt_reg == FLUSH_LAST) begin
              cnt_reg <= 11'h000;
              if (!half_reg) begin
                half_reg <= 1'b1;
                state_reg <= ST_VT;
              end else if (code_reg[CODE_SKIP_BIT]) begin
                state_reg <= ST_POST;
              end else begin
                half_reg <= 1'b0;
                pair_reg <= pair_reg + 8'h01;
                state_reg <= ST_ROWSEL;
              end
            end
          end
        end
        ST_POST: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 11'h001;
            if (cnt_reg == POST_LAST) begin
              state_reg <= ST_FT;
              cnt_reg <= 11'h000;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_vshift <= 1'b0;
      o_hmode <= 1'b0;
      o_hpix <= 1'b0;
      o_frame_start <= 1'b0;
    end else begin
      o_vshift <= (state_reg == ST_FT) || (state_reg == ST_VT) || (state_reg == ST_POST);
      o_hmode <= (state_reg == ST_FLUSH) || (state_reg == ST_DUMP);
      o_hpix <= tick && (cnt_reg >= PIX_FIRST) && (cnt_reg <= PIX_LAST) &&
                ((state_reg == ST_FLUSH) || (state_reg == ST_DUMP));
      o_frame_start <= frame_go;
    end
  end

  // ==========================================
  // Event acceptance and word formatting
  logic evt_acc;
  logic s1_valid;
  logic [8:0] s1_x;
  logic [8:0] s1_y;
  logic [3:0] s1_id;
  logic [7:0] s1_h;
  logic [7:0] s1_mx;
  logic [7:0] s1_nx;
  logic [7:0] s1_my;
  logic [7:0] s1_ny;
  logic [1:0] tag_cnt_reg;
  logic first_x_reg;
  logic pend_valid_reg;
  logic [23:0] pend_reg;
  logic [23:0] w_a;
  logic [23:0] w_b;
  logic [3:0] fld;
  logic two_words;

  function automatic logic [23:0] cwep_odd(input logic [22:0] b);
    return {b, ~^b};
  endfunction

  assign evt_acc = i_evt_valid && send_reg && pix_phase && code_reg[1:0] == CODE_READ_EVT &&
                   win_id_reg != 4'h0 && i_evt_height >= thresh_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s1_valid <= 1'b0;
    end else begin
      s1_valid <= evt_acc;
    end
    if (evt_acc) begin
      s1_x <= x_pix;
      s1_y <= y_pix;
      s1_id <= win_id_reg;
      s1_h <= i_evt_height;
      s1_mx <= i_evt_mx;
      s1_nx <= i_evt_nx;
      s1_my <= i_evt_my;
      s1_ny <= i_evt_ny;
    end
  end

  always_comb begin
    fld = mode_reg[0] ? {s1_y[8:7], s1_x[8:7]} : s1_id;
    two_words = mode_reg[2];
    w_b = 24'h00_0000;
    unique case (mode_reg)
      3'h0, 3'h1: w_a = cwep_odd({1'b0, cy_reg[2:1], s1_y[6:0], cx_reg[2:1], s1_x[6:0], fld});
      3'h2, 3'h3: w_a = cwep_odd({1'b0, cy_reg[2:0], s1_y[5:0], cx_reg[2:0], s1_x[5:0], fld});
      3'h4, 3'h5: begin
        w_a = cwep_odd({REC_XMN, s1_mx, s1_nx, 4'h0});
        w_b = cwep_odd({REC_YMN, s1_my, s1_ny, 4'h0});
      end
      default: begin
        w_a = cwep_odd({REC_HGT, s1_h, 12'h000});
        w_b = cwep_odd({REC_ENE, 20'h0_0000});
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      send_reg <= 1'b0;
      tag_cnt_reg <= 2'h0;
      first_x_reg <= 1'b0;
      pend_valid_reg <= 1'b0;
      pend_reg <= 24'h00_0000;
      o_word <= 24'h00_0000;
      o_word_valid <= 1'b0;
    end else begin
      o_word_valid <= 1'b0;
      if (frame_go) begin
        send_reg <= integ_reg;
        tag_cnt_reg <= (integ_reg && tag_en_reg) ? TAG_WORDS : 2'h0;
      end
      if (tag_cnt_reg != 2'h0) begin
        o_word <= 24'h00_0000;
        o_word_valid <= 1'b1;
        tag_cnt_reg <= tag_cnt_reg - 2'h1;
      end else if (s1_valid) begin
        o_word_valid <= 1'b1;
        if (two_words && !mode_reg[1] && first_x_reg) begin
          o_word <= w_b;
          first_x_reg <= 1'b0;
        end else begin
          o_word <= w_a;
          pend_reg <= w_b;
          pend_valid_reg <= two_words;
        end
      end else if (pend_valid_reg) begin
        o_word <= pend_reg;
        o_word_valid <= 1'b1;
        pend_valid_reg <= 1'b0;
      end
      if (frame_go) begin
        first_x_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_flush_length: assert property (
    (state_reg == ST_FLUSH && tick && cnt_reg == FLUSH_LAST) |=> state_reg != ST_FLUSH)
    else $error("Flush did not end after its last tick");
  chk_flush_early: assert property (
    (state_reg == ST_FLUSH && tick && cnt_reg < FLUSH_LAST) |=> state_reg == ST_FLUSH)
    else $error("Flush ended before all pixels");
  chk_ft_to_dump: assert property (
    (state_reg == ST_FT && tick && cnt_reg == FT_LAST) |=> state_reg == ST_DUMP && cnt_reg == 11'h000)
    else $error("Frame transfer did not end in a dump");
  chk_vt_length: assert property (
    (state_reg == ST_VT && tick && cnt_reg == VT_LAST && code_reg[1]) |=> state_reg == ST_FLUSH)
    else $error("Vertical shift not followed by flush");
  chk_skip_end: assert property (
    (state_reg == ST_FLUSH && tick && cnt_reg == FLUSH_LAST && half_reg && code_reg[CODE_SKIP_BIT])
      |=> state_reg == ST_POST)
    else $error("Skip code did not end the frame");
  chk_post_to_ft: assert property (
    (state_reg == ST_POST && tick && cnt_reg == POST_LAST) |=> state_reg == ST_FT && o_frame_start)
    else $error("Post rows not followed by transfer");
  chk_accept_gate: assert property (
    evt_acc |-> win_id_reg != 4'h0 && code_reg[1:0] == CODE_READ_EVT && i_evt_height >= thresh_reg)
    else $error("Event accepted outside a window");
  chk_event_word: assert property (
    evt_acc |=> ##1 o_word_valid && (^o_word))
    else $error("Accepted event gave no odd parity word");
  chk_tag_words: assert property (
    (frame_go && integ_reg && tag_en_reg) |=> ##1 o_word_valid && o_word == 24'h00_0000 ##1
      o_word_valid && o_word == 24'h00_0000)
    else $error("Frame tags missing");
  chk_send_gate: assert property (
    (!send_reg && !s1_valid && !pend_valid_reg && tag_cnt_reg == 2'h0) |=> !o_word_valid)
    else $error("Word sent while integration off");
  chk_pair_order: assert property (
    (state_reg == ST_ROWSEL && $past(state_reg) != ST_ROWSEL && $past(state_reg) != ST_DUMP)
      |-> pair_reg == $past(pair_reg) + 8'h01)
    else $error("Row pair skipped");

  cov_science_event: cover property (s1_valid && !mode_reg[2]);
  cov_eng_pair: cover property (s1_valid && mode_reg[2] ##1 o_word_valid ##1 o_word_valid);
  cov_skip_code: cover property (state_reg == ST_FLUSH && code_reg[CODE_SKIP_BIT] ##1 state_reg == ST_POST);
  cov_frame_loop: cover property (state_reg == ST_POST ##1 state_reg == ST_FT);

endmodule

// ### sim/cwep_ddp_model.sv
// Purpose: Downstream receiver model that records the first 32 words, frame tag words and event words alike
// Assumes: One word per o_word_valid pulse, same clock as the block
// Notes: The bench reads the captured words through the hierarchy

`timescale 1ns/100ps

module cwep_ddp_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [23:0] i_word,
  input wire logic i_word_valid
);
  // ==========================================
  // Capture
  logic [23:0] words [0:31];
  int n_words;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      n_words <= 0;
    end else if (i_word_valid === 1'h1 && n_words < 32) begin
      words[n_words] <= i_word;
      n_words <= n_words + 1;
    end
  end
endmodule

// ### sim/tb_cwep_top.sv
// Purpose: Self-checking bench for the window readout and event formatter
// Assumes: APB master with one wait state answer, 200 MHz clock
// Notes: One full frame plus the start of the next one is run

`timescale 1ns/100ps

module tb_cwep_top import cwep_pkg::*; ;
  // ==========================================
  // Signals
  localparam logic [31:0] CTRL_ON = 32'h38;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, evt_valid = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] evt_height = 8'h00, evt_mx = 8'h33, evt_nx = 8'h44, evt_my = 8'h55, evt_ny = 8'h66;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, vshift, hmode, hpix, frame_start, word_valid, hmode_q;
  logic [23:0] word;
  logic [23:0] exp_v [0:31];
  logic [23:0] exp_m [0:31];
  int num_errors = 0, n_compared = 0, n_exp = 0;
  int fs_n = 0, flush_n = 0, pix_in = 0, hpix_n = 0, hmode_n = 0, vs_n = 0;

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  cwep_top i_cwep_top (.i_core_clk(core_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_evt_valid(evt_valid), .i_evt_height(evt_height), .i_evt_mx(evt_mx),
    .i_evt_nx(evt_nx), .i_evt_my(evt_my), .i_evt_ny(evt_ny), .o_vshift(vshift), .o_hmode(hmode),
    .o_hpix(hpix), .o_frame_start(frame_start), .o_word(word), .o_word_valid(word_valid));

  cwep_ddp_model i_cwep_ddp_model (.i_core_clk(core_clk), .i_rst(rst), .i_word(word),
    .i_word_valid(word_valid));

  // ==========================================
  // Frame monitor
  always @(posedge core_clk) begin
    hmode_q <= hmode;
    if (frame_start === 1'h1) begin
      fs_n <= fs_n + 1;
    end
    if (hmode === 1'h1 && hmode_q !== 1'h1) begin
      flush_n <= flush_n + 1;
      pix_in <= 0;
    end else if (hpix === 1'h1) begin
      pix_in <= pix_in + 1;
    end
    if (fs_n == 1) begin
      hpix_n <= hpix_n + (hpix === 1'h1);
      hmode_n <= hmode_n + (hmode === 1'h1);
      vs_n <= vs_n + (vshift === 1'h1);
    end
  end

  // ==========================================
  // Tasks
  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      num_errors++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rchk(input logic [11:0] addr, input logic [31:0] exp, input string what);
    apb(1'h0, addr, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic evt(input logic [7:0] h);
    @(posedge core_clk);
    evt_valid <= 1'h1;
    evt_height <= h;
    @(posedge core_clk);
    evt_valid <= 1'h0;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic wait_for(input int sel, input int target);
    int n;
    n = 0;
    while ((sel == 0 ? fs_n : (sel == 1 ? flush_n : pix_in)) < target && n < 100000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 100000) begin
      num_errors++;
    end
  endtask

  task automatic expect_word(input logic [23:0] v, input logic [23:0] m);
    exp_v[n_exp] = v;
    exp_m[n_exp] = m;
    n_exp++;
  endtask

  function automatic logic [23:0] pw(input logic [23:0] w);
    return {w[23:1], ~^w[23:1]};
  endfunction

  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    rchk(REG_CTRL, 32'h8, "ctrl reset");
    rchk(REG_THRESH, 32'hF, "thresh reset");
    rchk(REG_STATUS, 32'h1, "status idle");
    rchk(12'h020, 32'h0, "unmapped read");
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'h1, REG_THRESH, 32'h20);
    rchk(REG_THRESH, 32'h20, "thresh");
    apb(1'h1, REG_TADDR, {14'h0, TSEL_ROW, 16'h0});
    apb(1'h1, REG_TDATA, 32'h0);
    apb(1'h1, REG_TDATA, 32'(CODE_READ_EVT) | (32'h1 << CODE_SKIP_BIT));
    apb(1'h1, REG_TADDR, {14'h0, TSEL_CENX, 16'h3344});
    apb(1'h1, REG_TDATA, 32'h5);
    apb(1'h1, REG_TADDR, {14'h0, TSEL_CENY, 16'h5566});
    apb(1'h1, REG_TDATA, 32'h6);
    apb(1'h1, REG_TADDR, {14'h0, TSEL_WIN, 16'h0100});
    for (int i = 0; i < 204; i++) begin
      apb(1'h1, REG_TDATA, i < 100 ? 32'h5 : 32'h0);
    end
    rchk(REG_TDATA, 32'h0, "tdata read");
    apb(1'h1, REG_CTRL, CTRL_ON);
    expect_word(24'h0, 24'hFFFFFF);
    expect_word(24'h0, 24'hFFFFFF);
    wait_for(0, 1);
    wait_for(1, 1);
    wait_for(2, 10);
    evt(8'h40);
    wait_for(1, 2);
    wait_for(2, 5);
    evt(8'h1F);
    evt(8'h20);
    expect_word(24'h60A00A, 24'hFFF01E);
    apb(1'h1, REG_CTRL, CTRL_ON | 32'h3);
    evt(8'h20);
    expect_word(24'h60A800, 24'hFFF81E);
    apb(1'h1, REG_CTRL, CTRL_ON | 32'h4);
    evt(8'h33);
    evt(8'h33);
    expect_word(pw({REC_YMN, 8'h55, 8'h66, 5'h0}), 24'hFFFFFF);
    expect_word(pw({REC_XMN, 8'h33, 8'h44, 5'h0}), 24'hFFFFFF);
    expect_word(pw({REC_YMN, 8'h55, 8'h66, 5'h0}), 24'hFFFFFF);
    apb(1'h1, REG_CTRL, CTRL_ON | 32'h6);
    evt(8'h33);
    expect_word(pw({REC_HGT, 8'h33, 8'h00, 5'h0}), 24'hFFFFFF);
    expect_word(pw({REC_ENE, 21'h0}), 24'hFFFFFF);
    apb(1'h1, REG_CTRL, CTRL_ON | 32'h7);
    evt(8'h33);
    expect_word(pw({REC_HGT, 8'h33, 8'h00, 5'h0}), 24'hFFFFFF);
    expect_word(pw({REC_ENE, 21'h0}), 24'hFFFFFF);
    apb(1'h1, REG_CTRL, CTRL_ON | 32'h5);
    evt(8'h33);
    expect_word(pw({REC_XMN, 8'h33, 8'h44, 5'h0}), 24'hFFFFFF);
    expect_word(pw({REC_YMN, 8'h55, 8'h66, 5'h0}), 24'hFFFFFF);
    apb(1'h1, REG_CTRL, CTRL_ON | 32'h1);
    evt(8'h20);
    expect_word(24'h60A000, 24'hFFF01E);
    apb(1'h1, REG_CTRL, CTRL_ON | 32'h2);
    evt(8'h20);
    expect_word(24'h60A80A, 24'hFFF81E);
    apb(1'h1, REG_CTRL, CTRL_ON);
    wait_for(2, 230);
    evt(8'h40);
    wait_for(0, 2);
    repeat (30) @(posedge core_clk);
    expect_word(24'h0, 24'hFFFFFF);
    expect_word(24'h0, 24'hFFFFFF);
    check("word count", 32'(i_cwep_ddp_model.n_words), 32'(n_exp));
    for (int i = 0; i < n_exp; i++) begin
      check("word", {8'h0, i_cwep_ddp_model.words[i] & exp_m[i]}, {8'h0, exp_v[i]});
    end
    for (int i = 2; i < 15; i++) begin
      check("parity", {31'h0, ^i_cwep_ddp_model.words[i]}, 32'h1);
    end
    check("pixel clocks", 32'(hpix_n), 32'(3 * ROW_PIX));
    check("flush cycles", 32'(hmode_n), 32'(3 * FLUSH_TICKS * HT_CYC));
    check("shift cycles", 32'(vs_n), 32'((FT_SHIFTS + 4 + POST_ROWS) * VT_TICKS * HT_CYC));
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end
endmodule
